//--- tb/dtp_checker_assertions.sv
`timescale 1ns/100ps
module dtp_checker (
  input wire CORE_CLK,
  input wire RST_N,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire PORT_PIN_A_OUT,
  input wire PORT_PIN_A_OE,
  input wire PORT_PIN_B_OUT,
  input wire PORT_PIN_B_OE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  reg sel_q, sel2_q;
  reg [1:0] bit_q;
  // pin enable may lag the select write by one register stage
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_q <= 1'b0;
      sel2_q <= 1'b0;
      bit_q <= 2'h0;
    end else begin
      sel_q <= WR && ADDR == 4'h0;
      sel2_q <= sel_q;
      bit_q <= WDATA[1:0];
    end
  end
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  a_pin_a_gated: assert property (!PORT_PIN_A_OE |-> !PORT_PIN_A_OUT)
    else $error("pin a driven while disabled");
  a_pin_b_gated: assert property (!PORT_PIN_B_OE |-> !PORT_PIN_B_OUT)
    else $error("pin b driven while disabled");
  a_oe_a_hold: assert property
    (!sel_q && !sel2_q |-> $stable(PORT_PIN_A_OE))
    else $error("pin a enable moved without write");
  a_oe_b_hold: assert property
    (!sel_q && !sel2_q |-> $stable(PORT_PIN_B_OE))
    else $error("pin b enable moved without write");
  a_oe_a_write: assert property
    (sel_q |=> PORT_PIN_A_OE == $past(bit_q[0]))
    else $error("pin a enable not taken from write");
  a_oe_b_write: assert property
    (sel_q |=> PORT_PIN_B_OE == $past(bit_q[1]))
    else $error("pin b enable not taken from write");
  a_unmapped_read: assert property (RD && ADDR > 4'hB |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_high_bits_read: assert property
    (RD && (ADDR == 4'h4 || ADDR == 4'h8) |=> RDATA[7:4] == 4'h0)
    else $error("high bits register upper nibble set");
  cover property (WR && ADDR == 4'h0);
  cover property ($rose(PORT_PIN_A_OUT));
  cover property ($rose(PORT_PIN_B_OUT));
endmodule

//--- tb/test_dtp_top.sv
`timescale 1ns/100ps
module test_dtp_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] ad = 4'h0;
  reg [7:0] wd = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [7:0] rdata;
  wire [1:0] po, oe;
  integer err_count = 0;
  integer check_count = 0;
  integer i, hi, lo, t, k;
  always #5 clk = ~clk;
  dtp_top dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(ad), .WDATA(wd),
    .WR(wr), .RD(rd), .RDATA(rdata), .PORT_PIN_A_OUT(po[0]),
    .PORT_PIN_A_OE(oe[0]), .PORT_PIN_B_OUT(po[1]), .PORT_PIN_B_OE(oe[1]));
  task final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e, input [63:0] n);
    check_count = check_count + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("ERROR %s exp %0d got %0d", n, e, g);
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [3:0] a, input [7:0] e);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e, "rdata");
  endtask
  task rise(input c);
    for (t = 0; t < 9999 && po[c] !== 1'b0; t = t + 1) @(negedge clk);
    for (t = t; t < 9999 && po[c] !== 1'b1; t = t + 1) @(negedge clk);
    if (t == 9999) begin
      err_count = err_count + 1;
      final_report;
    end
  endtask
  // counts start at the rising sample, so h0 covers samples already seen
  task meas(input c, input integer h0);
    for (hi = h0; hi < 9999; hi = hi + 1) begin
      @(negedge clk);
      if (po[c] !== 1'b1) break;
    end
    for (lo = 1; lo < 9999; lo = lo + 1) begin
      @(negedge clk);
      if (po[c] !== 1'b0) break;
    end
    if (hi == 9999 || lo == 9999) begin
      err_count = err_count + 1;
      final_report;
    end
  endtask
  // timer is stopped before period and duty are loaded
  task cfg(input c, input [7:0] m, input [9:0] pr, input [9:0] dy);
    wr_reg(c ? 4'h5 : 4'h1, m & 8'hFE);
    wr_reg(c ? 4'h6 : 4'h2, pr[7:0]);
    wr_reg(c ? 4'h7 : 4'h3, dy[7:0]);
    wr_reg(c ? 4'h8 : 4'h4, {4'h0, pr[9:8], dy[9:8]});
    wr_reg(c ? 4'h5 : 4'h1, m);
  endtask
  task pw(input c, input p, input [1:0] cs, input [9:0] pr, input [9:0] dy);
    k = (cs == 2'd0) ? 25 : (cs == 2'd1) ? 50 : 200;
    cfg(c, {p, 3'b010, cs, 2'b01}, pr, dy);
    rise(c);
    meas(c, 1);
    meas(c, 1);
    chk(hi, (p ? dy : pr + 1 - dy) * k, "high");
    chk(lo, (p ? pr + 1 - dy : dy) * k, "low");
  endtask
  task steady(input c, input v);
    repeat (150) @(negedge clk);
    hi = 0;
    repeat (300) begin
      @(negedge clk);
      if (po[c] !== v) hi = hi + 1;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i = i + 1) rd_chk(i, 8'h00);
    for (i = 1; i < 9; i = i + 1) wr_reg(i, 8'hC2 + i);
    wr_reg(4'hD, 8'hFF);
    for (i = 1; i < 9; i = i + 1)
      rd_chk(i, (8'hC2 + i) & ((i % 4) ? 8'hFF : 8'h0F));
    rd_chk(4'hD, 8'h00);
    wr_reg(4'h0, 8'h01);
    repeat (2) @(negedge clk);
    chk(oe, 2'b01, "oe");
    wr_reg(4'h0, 8'h03);
    for (i = 0; i < 4; i = i + 1) pw(0, 1, i, 3, 1);
    pw(0, 0, 0, 3, 1);
    pw(1, 1, 0, 10'h102, 10'h101);
    cfg(0, 8'hA1, 3, 1);
    rise(0);
    wr_reg(4'h3, 8'h02);
    meas(0, 2);
    chk(hi, 25, "olddy");
    meas(0, 1);
    chk(hi, 50, "newdy");
    wr_reg(4'h2, 8'h05);
    meas(0, 1);
    meas(0, 1);
    chk(hi, 50, "keepdy");
    chk(lo, 100, "newpr");
    cfg(0, 8'hA1, 3, 3);
    steady(0, 1);
    chk(hi, 0, "fullhi");
    wr_reg(4'h0, 8'h02);
    repeat (3) @(negedge clk);
    chk({po[0], oe[0]}, 0, "pinoff");
    wr_reg(4'h0, 8'h03);
    cfg(0, 8'h21, 3, 3);
    steady(0, 0);
    chk(hi, 0, "fulllo");
    cfg(0, 8'hA1, 3, 0);
    steady(0, 0);
    chk(hi, 0, "zerolo");
    cfg(0, 8'h21, 3, 0);
    steady(0, 1);
    chk(hi, 0, "zerohi");
    final_report;
  end
endmodule
bind dtp_top dtp_checker chk_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PORT_PIN_A_OUT(PORT_PIN_A_OUT), .PORT_PIN_A_OE(PORT_PIN_A_OE),
  .PORT_PIN_B_OUT(PORT_PIN_B_OUT), .PORT_PIN_B_OE(PORT_PIN_B_OE));

//--- verilog/dtp_channel.v
`timescale 1ns/100ps
`include "dtp_defines.vh"

module dtp_channel #(
  parameter RES = 10,
  parameter DIV_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire pwm_mode,
  input wire output_polarity,
  input wire [1:0] clock_select,
  input wire [RES-1:0] period,
  input wire [RES-1:0] duty_master,
  output reg wave_q,
  output reg [RES-1:0] count_q,
  output reg [RES-1:0] duty_slave_q
);

  reg [DIV_W-1:0] pre_q;
  reg [DIV_W-1:0] pre_top;
  wire tick;
  wire at_period;
  wire [RES-1:0] count_next;
  wire [RES-1:0] duty_next;
  reg wave_d;

  localparam [31:0] TOP0 = `DTP_SRC0_CYC - 1;
  localparam [31:0] TOP1 = `DTP_SRC1_CYC - 1;
  localparam [31:0] TOP2 = `DTP_SRC2_CYC - 1;

  // source tick period chosen by the two-bit clock select
  always @* begin
    case (clock_select)
      2'h0: pre_top = TOP0[DIV_W-1:0];
      2'h1: pre_top = TOP1[DIV_W-1:0];
      2'h2: pre_top = TOP2[DIV_W-1:0];
      default: pre_top = TOP2[DIV_W-1:0];
    endcase
  end

  assign tick = run && (pre_q == pre_top);
  assign at_period = (count_q == period);
  assign count_next = at_period ? {RES{1'b0}} : count_q + 1'b1;
  // while running in pwm mode, master duty moves to the slave only at the period match
  assign duty_next = at_period ? duty_master : duty_slave_q;

  // active level while count is below the buffered duty, inverse after;
  // duty == period keeps active, duty zero keeps inactive
  always @* begin
    if (duty_next == {RES{1'b0}})
      wave_d = ~output_polarity;
    else if (duty_next == period)
      wave_d = output_polarity;
    else if (count_next < duty_next)
      wave_d = output_polarity;
    else
      wave_d = ~output_polarity;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= {DIV_W{1'b0}};
      count_q <= {RES{1'b0}};
      duty_slave_q <= {RES{1'b0}};
      wave_q <= 1'b0;
    end else begin
      if (!run) begin
        pre_q <= {DIV_W{1'b0}};
      end else if (tick) begin
        pre_q <= {DIV_W{1'b0}};
      end else begin
        pre_q <= pre_q + 1'b1;
      end
      if (!pwm_mode) begin
        // not modulating (pwm bit clear): idle inactive, slave tracks master
        count_q <= {RES{1'b0}};
        duty_slave_q <= duty_master;
        wave_q <= ~output_polarity;
      end else if (tick) begin
        count_q <= count_next;
        duty_slave_q <= duty_next;
        wave_q <= wave_d;
      end else if (!run) begin
        // stopped: slave follows master so the first cycle uses new duty
        duty_slave_q <= duty_master;
      end
    end
  end

endmodule

//--- verilog/dtp_defines.vh
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH

// register indices on the plain register port
`define DTP_ADDR_W 4
`define DTP_REG_PSEL 4'h0
`define DTP_REG_A_MODE 4'h1
`define DTP_REG_A_PER 4'h2
`define DTP_REG_A_DUTY 4'h3
`define DTP_REG_A_HIGH 4'h4
`define DTP_REG_B_MODE 4'h5
`define DTP_REG_B_PER 4'h6
`define DTP_REG_B_DUTY 4'h7
`define DTP_REG_B_HIGH 4'h8
`define DTP_REG_A_CNT_LO 4'h9
`define DTP_REG_B_CNT_LO 4'hA
`define DTP_REG_STATUS 4'hB

// port select register fields
`define DTP_PSEL_A_OE 0
`define DTP_PSEL_B_OE 1

// timer mode register fields
`define DTP_MODE_START 0
`define DTP_MODE_CK_LO 2
`define DTP_MODE_CK_HI 3
`define DTP_MODE_PWM 5
`define DTP_MODE_POL 7

// high-bits register fields
`define DTP_HIGH_DUTY_LO 0
`define DTP_HIGH_DUTY_HI 1
`define DTP_HIGH_PER_LO 2
`define DTP_HIGH_PER_HI 3

`define DTP_RESET_BYTE 8'h00

// counting source: one count per source period
`define DTP_CLK_PERIOD_NS 10
`define DTP_SRC0_NS 250
`define DTP_SRC1_NS 500
`define DTP_SRC2_NS 2000
`define DTP_SRC0_CYC (`DTP_SRC0_NS / `DTP_CLK_PERIOD_NS)
`define DTP_SRC1_CYC (`DTP_SRC1_NS / `DTP_CLK_PERIOD_NS)
`define DTP_SRC2_CYC (`DTP_SRC2_NS / `DTP_CLK_PERIOD_NS)

`endif

//--- verilog/dtp_top.v
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "dtp_defines.vh"

// Contract
// - two PWM channels, own pins, 10-bit
// - pin driven only when enable bit set
// - period: low byte plus high bits 3:2
// - duty: low byte plus high bits 1:0
// - duty buffered, copied at period match
// - running duty change waits period end
// - period-only change keeps current duty
// - polarity bit selects active level
// - duty equals period: constant active level
// - duty zero: constant inactive level
// - clock select picks counting source rate
module dtp_top #(
  parameter RES = 10,
  parameter DIV_W = 8
) (
  input wire CORE_CLK,
  input wire RST_N,
  input wire [`DTP_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  output reg PORT_PIN_A_OUT,
  output reg PORT_PIN_A_OE,
  output reg PORT_PIN_B_OUT,
  output reg PORT_PIN_B_OE
);

  reg [7:0] port_select_reg_zero_q;
  reg [7:0] timer_b_mode_reg_q;
  reg [7:0] timer_d_mode_reg_q;
  reg [7:0] ch_a_period_low_q;
  reg [7:0] ch_b_period_low_q;
  reg [7:0] ch_a_duty_low_q;
  reg [7:0] ch_b_duty_low_q;
  reg [7:0] ch_a_high_bits_q;
  reg [7:0] ch_b_high_bits_q;
  reg [7:0] rdata_d;

  wire [RES-1:0] a_period;
  wire [RES-1:0] b_period;
  wire [RES-1:0] a_duty;
  wire [RES-1:0] b_duty;
  wire pwm_ch_a_out;
  wire pwm_ch_b_out;
  wire [RES-1:0] a_count;
  wire [RES-1:0] b_count;
  wire [RES-1:0] a_slave;
  wire [RES-1:0] b_slave;
  wire pwm_ch_a_pin_enable;
  wire pwm_ch_b_pin_enable;

  function is_write;
    input [`DTP_ADDR_W-1:0] a;
    input [`DTP_ADDR_W-1:0] target;
    begin
      is_write = WR && (a == target);
    end
  endfunction

  // 10-bit values are assembled from the low byte and two high bits
  assign a_period = {ch_a_high_bits_q[`DTP_HIGH_PER_HI:`DTP_HIGH_PER_LO],
                     ch_a_period_low_q};
  assign b_period = {ch_b_high_bits_q[`DTP_HIGH_PER_HI:`DTP_HIGH_PER_LO],
                     ch_b_period_low_q};
  assign a_duty = {ch_a_high_bits_q[`DTP_HIGH_DUTY_HI:`DTP_HIGH_DUTY_LO],
                   ch_a_duty_low_q};
  assign b_duty = {ch_b_high_bits_q[`DTP_HIGH_DUTY_HI:`DTP_HIGH_DUTY_LO],
                   ch_b_duty_low_q};

  assign pwm_ch_a_pin_enable = port_select_reg_zero_q[`DTP_PSEL_A_OE];
  assign pwm_ch_b_pin_enable = port_select_reg_zero_q[`DTP_PSEL_B_OE];

  // a period write never touches the slave duty, so the active-level time is
  // kept while the frequency changes
  dtp_channel #(.RES(RES), .DIV_W(DIV_W)) u_ch_a (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .run(timer_b_mode_reg_q[`DTP_MODE_START]),
    .pwm_mode(timer_b_mode_reg_q[`DTP_MODE_PWM]),
    .output_polarity(timer_b_mode_reg_q[`DTP_MODE_POL]),
    .clock_select(timer_b_mode_reg_q[`DTP_MODE_CK_HI:`DTP_MODE_CK_LO]),
    .period(a_period),
    .duty_master(a_duty),
    .wave_q(pwm_ch_a_out),
    .count_q(a_count),
    .duty_slave_q(a_slave)
  );

  dtp_channel #(.RES(RES), .DIV_W(DIV_W)) u_ch_b (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .run(timer_d_mode_reg_q[`DTP_MODE_START]),
    .pwm_mode(timer_d_mode_reg_q[`DTP_MODE_PWM]),
    .output_polarity(timer_d_mode_reg_q[`DTP_MODE_POL]),
    .clock_select(timer_d_mode_reg_q[`DTP_MODE_CK_HI:`DTP_MODE_CK_LO]),
    .period(b_period),
    .duty_master(b_duty),
    .wave_q(pwm_ch_b_out),
    .count_q(b_count),
    .duty_slave_q(b_slave)
  );

  always @* begin
    case (ADDR)
      `DTP_REG_PSEL: rdata_d = port_select_reg_zero_q;
      `DTP_REG_A_MODE: rdata_d = timer_b_mode_reg_q;
      `DTP_REG_A_PER: rdata_d = ch_a_period_low_q;
      `DTP_REG_A_DUTY: rdata_d = ch_a_duty_low_q;
      `DTP_REG_A_HIGH: rdata_d = {4'h0, ch_a_high_bits_q[3:0]};
      `DTP_REG_B_MODE: rdata_d = timer_d_mode_reg_q;
      `DTP_REG_B_PER: rdata_d = ch_b_period_low_q;
      `DTP_REG_B_DUTY: rdata_d = ch_b_duty_low_q;
      `DTP_REG_B_HIGH: rdata_d = {4'h0, ch_b_high_bits_q[3:0]};
      `DTP_REG_A_CNT_LO: rdata_d = a_count[7:0];
      `DTP_REG_B_CNT_LO: rdata_d = b_count[7:0];
      `DTP_REG_STATUS: rdata_d = {a_count[9:8], b_count[9:8],
                                  a_slave[9:8], b_slave[9:8]};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_select_reg_zero_q <= `DTP_RESET_BYTE;
      timer_b_mode_reg_q <= `DTP_RESET_BYTE;
      timer_d_mode_reg_q <= `DTP_RESET_BYTE;
      ch_a_period_low_q <= `DTP_RESET_BYTE;
      ch_b_period_low_q <= `DTP_RESET_BYTE;
      ch_a_duty_low_q <= `DTP_RESET_BYTE;
      ch_b_duty_low_q <= `DTP_RESET_BYTE;
      ch_a_high_bits_q <= `DTP_RESET_BYTE;
      ch_b_high_bits_q <= `DTP_RESET_BYTE;
      RDATA <= 8'h00;
      PORT_PIN_A_OUT <= 1'b0;
      PORT_PIN_A_OE <= 1'b0;
      PORT_PIN_B_OUT <= 1'b0;
      PORT_PIN_B_OE <= 1'b0;
    end else begin
      // writes while running land at once; only the duty is shielded
      // by the slave copy, which is why software stops the clock first
      if (is_write(ADDR, `DTP_REG_PSEL))
        port_select_reg_zero_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_A_MODE))
        timer_b_mode_reg_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_B_MODE))
        timer_d_mode_reg_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_A_PER))
        ch_a_period_low_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_B_PER))
        ch_b_period_low_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_A_DUTY))
        ch_a_duty_low_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_B_DUTY))
        ch_b_duty_low_q <= WDATA;
      if (is_write(ADDR, `DTP_REG_A_HIGH))
        ch_a_high_bits_q <= {4'h0, WDATA[3:0]};
      if (is_write(ADDR, `DTP_REG_B_HIGH))
        ch_b_high_bits_q <= {4'h0, WDATA[3:0]};
      RDATA <= RD ? rdata_d : 8'h00;
      // pin carries the wave only with its enable set
      PORT_PIN_A_OUT <= pwm_ch_a_pin_enable & pwm_ch_a_out;
      PORT_PIN_A_OE <= pwm_ch_a_pin_enable;
      PORT_PIN_B_OUT <= pwm_ch_b_pin_enable & pwm_ch_b_out;
      PORT_PIN_B_OE <= pwm_ch_b_pin_enable;
    end
  end

endmodule
